// ==== design/triple_half_bridge_control.sv ====
// Control and protection logic of a three-channel half-bridge driver
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`default_nettype none
module triple_half_bridge_control #(
  parameter int unsigned WAKE_CYCLES = half_bridge_pkg::WAKE_CYCLES,
  parameter int unsigned OCP_CYCLES  = half_bridge_pkg::OCP_CYCLES
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire half_bridge_pkg::bridge_cmd_type bridge_cmd,
  input  wire logic                         low_power_request_n,
  input  wire logic                         fault_clear_n,
  input  wire logic [2:0]                   high_side_limit,
  input  wire logic [2:0]                   low_side_limit,
  input  wire logic                         motor_supply_low,
  input  wire logic [7:0]                   die_temp_c,
  output logic [2:0]                        phase_output,
  output logic [2:0]                        phase_output_oe,
  output logic                              charge_pump_run,
  output logic                              error_indicator_n_out,
  output logic                              error_indicator_n_oe,
  output logic                              irq,
  input  wire logic [3:0]                   address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  input  wire logic [3:0]                   byteenable,
  output logic [31:0]                       readdata,
  output logic                              waitrequest
);
  localparam int unsigned NCH  = half_bridge_pkg::CHANNELS;
  localparam int unsigned EVW  = half_bridge_pkg::EV_WIDTH;
  localparam int unsigned SW   = 15;
  localparam int unsigned WW   = $clog2(WAKE_CYCLES + 1);
  localparam int unsigned OW   = $clog2(OCP_CYCLES + 1);
  localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_CYCLES - 1);
  localparam logic [OW-1:0] OCP_LAST  = OW'(OCP_CYCLES - 1);
  // Active-low pins idle high so reset does not look like a request
  localparam logic [SW-1:0] SYNC_INIT = 15'h6000;

  // Reset release through two flops; the block's power-up reset
  logic rst_s1_q;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // Pin synchronisers: three flops, a change counts once stages agree
  wire  [SW-1:0] pins_raw = {low_power_request_n, fault_clear_n,
                             motor_supply_low, high_side_limit,
                             low_side_limit, bridge_cmd.enable,
                             bridge_cmd.level};
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] filt_q;
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          s1_q[gi]   <= SYNC_INIT[gi];
          s2_q[gi]   <= SYNC_INIT[gi];
          s3_q[gi]   <= SYNC_INIT[gi];
          filt_q[gi] <= SYNC_INIT[gi];
        end else begin
          s1_q[gi] <= pins_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            filt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Temperature code moves only as a whole word, never bit by bit
  logic [7:0] t1_q;
  logic [7:0] t2_q;
  logic [7:0] t3_q;
  logic [7:0] temp_f;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      t1_q   <= 8'h00;
      t2_q   <= 8'h00;
      t3_q   <= 8'h00;
      temp_f <= 8'h00;
    end else begin
      t1_q <= die_temp_c;
      t2_q <= t1_q;
      t3_q <= t2_q;
      if (t2_q == t3_q) begin
        temp_f <= t3_q;
      end
    end
  end

  wire           sleep_req_f = ~filt_q[14];
  wire           clr_f       = filt_q[13];
  wire           supply_low_lockout_f      = filt_q[12];
  wire [NCH-1:0] limit_f     = filt_q[11:9] | filt_q[8:6];
  wire [NCH-1:0] en_f        = filt_q[5:3];
  wire [NCH-1:0] lvl_f       = filt_q[2:0];

  // Power state
  half_bridge_pkg::power_state_type state_q;
  half_bridge_pkg::power_state_type state_d;
  logic [WW-1:0] wake_cnt_q;
  wire           clearing  = ~clr_f;
  wire           wake_done = wake_cnt_q == WAKE_LAST;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      half_bridge_pkg::ST_SLEEP: begin
        if (!sleep_req_f) state_d = half_bridge_pkg::ST_WAKE;
      end
      half_bridge_pkg::ST_WAKE: begin
        if (sleep_req_f && !clearing) state_d = half_bridge_pkg::ST_SLEEP;
        else if (wake_done) state_d = half_bridge_pkg::ST_RUN;
      end
      half_bridge_pkg::ST_RUN: begin
        // Sleep is ignored while fault-clear is held low
        if (sleep_req_f && !clearing) state_d = half_bridge_pkg::ST_SLEEP;
      end
    endcase
  end

  wire asleep = state_q == half_bridge_pkg::ST_SLEEP;
  wire run    = state_q == half_bridge_pkg::ST_RUN;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q    <= half_bridge_pkg::ST_WAKE;
      wake_cnt_q <= '0;
    end else begin
      state_q    <= state_d;
      wake_cnt_q <= (state_q == half_bridge_pkg::ST_WAKE && !wake_done) ?
                    wake_cnt_q + WW'(1) : '0;
    end
  end

  // Over-temperature with hysteresis, self-clearing
  logic otemp_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      otemp_q <= 1'b0;
    end else if (temp_f > half_bridge_pkg::TEMP_TRIP_C) begin
      otemp_q <= 1'b1;
    end else if (temp_f < half_bridge_pkg::TEMP_RESUME_C) begin
      otemp_q <= 1'b0;
    end
  end

  // Logic reset by sleep, supply loss or fault-clear
  wire logic_reset = asleep | supply_low_lockout_f;
  wire latch_clear = logic_reset | clearing;
  wire global_off  = ~run | clearing | otemp_q | supply_low_lockout_f;

  // Per-channel overcurrent deglitch and latch
  logic [OW-1:0]  ocp_cnt_q [NCH];
  logic [NCH-1:0] ocp_q;
  logic [NCH-1:0] drive_d;
  logic [NCH-1:0] oe_q;
  logic [NCH-1:0] out_q;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      wire trip = ocp_cnt_q[gi] == OCP_LAST;
      assign drive_d[gi] = en_f[gi] & ~global_off & ~ocp_q[gi];
      always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          ocp_cnt_q[gi] <= '0;
          ocp_q[gi]     <= 1'b0;
        end else if (latch_clear) begin
          ocp_cnt_q[gi] <= '0;
          ocp_q[gi]     <= 1'b0;
        end else begin
          // Limit must stay active without a break for the full count
          ocp_cnt_q[gi] <= (limit_f[gi] && oe_q[gi] && !trip) ?
                           ocp_cnt_q[gi] + OW'(1) : '0;
          if (trip) ocp_q[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oe_q  <= '0;
      out_q <= '0;
    end else begin
      oe_q  <= drive_d;
      out_q <= lvl_f & drive_d;
    end
  end

  logic fault_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) fault_q <= 1'b0;
    else fault_q <= (|ocp_q) | otemp_q | supply_low_lockout_f;
  end

  assign phase_output          = out_q;
  assign phase_output_oe       = oe_q;
  assign charge_pump_run       = ~asleep;
  assign error_indicator_n_out = 1'b0;
  assign error_indicator_n_oe  = fault_q;

  // Events: sticky status, cleared by read, mask gates the interrupt
  logic [NCH-1:0] ocp_prev_q;
  logic           otemp_prev_q;
  logic           supply_low_lockout_prev_q;
  logic           run_prev_q;
  logic [EVW-1:0] status_q;
  logic [EVW-1:0] mask_q;
  logic           ack_q;
  logic [31:0]    rdata_q;
  wire  [EVW-1:0] events = {run & ~run_prev_q, supply_low_lockout_f & ~supply_low_lockout_prev_q,
                            otemp_q & ~otemp_prev_q, ocp_q & ~ocp_prev_q};
  wire  [EVW-1:0] live   = {run, supply_low_lockout_f, otemp_q, ocp_q};
  wire  [1:0]     word   = address[3:2];
  wire            taken  = ack_q & (read | write);
  wire            st_rd  = taken & read & word == half_bridge_pkg::STATUS_ADDR;
  wire            mk_wr  = taken & write & word == half_bridge_pkg::MASK_ADDR
                           & byteenable[0];
  // Only bits that were returned are cleared; a new event wins
  wire  [EVW-1:0] rd_bits = st_rd ? rdata_q[EVW-1:0] : '0;
  wire  [EVW-1:0] status_d = (status_q & ~rd_bits) | events;
  wire  [31:0]    rmux =
      (word == half_bridge_pkg::STATUS_ADDR) ? {26'h0, status_q} :
      (word == half_bridge_pkg::MASK_ADDR)   ? {26'h0, mask_q} :
      (word == half_bridge_pkg::LIVE_ADDR)   ? {26'h0, live} :
      half_bridge_pkg::UNMAPPED_DATA;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ocp_prev_q   <= '0;
      otemp_prev_q <= 1'b0;
      supply_low_lockout_prev_q  <= 1'b0;
      run_prev_q   <= 1'b0;
      status_q     <= '0;
      mask_q       <= half_bridge_pkg::MASK_RESET;
      ack_q        <= 1'b0;
      rdata_q      <= '0;
    end else begin
      ocp_prev_q   <= ocp_q;
      otemp_prev_q <= otemp_q;
      supply_low_lockout_prev_q  <= supply_low_lockout_f;
      run_prev_q   <= run;
      status_q     <= status_d;
      if (mk_wr) mask_q <= writedata[EVW-1:0];
      ack_q        <= (read | write) & ~ack_q;
      if (!ack_q) rdata_q <= rmux;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = (read | write) & ~ack_q;
  assign irq         = |(status_q & mask_q);

  // Checks
  sequence wake_entry;
    $past(state_q) == half_bridge_pkg::ST_SLEEP &&
    state_q == half_bridge_pkg::ST_WAKE;
  endsequence
  sequence not_running_yet;
    state_q != half_bridge_pkg::ST_RUN [*8];
  endsequence

  enable_gates_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (oe_q & ~$past(en_f)) == '0)
    else $error("Phase driven while its enable was low");
  level_follow_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    ((out_q ^ $past(lvl_f)) & oe_q) == '0)
    else $error("Driven phase does not follow its level input");
  pump_sleep_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    asleep |-> !charge_pump_run)
    else $error("Charge pump runs while asleep");
  clear_latch_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !clr_f |=> ocp_q == '0)
    else $error("Overcurrent latch survives fault clear");
  clear_off_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !clr_f |=> oe_q == '0)
    else $error("Driver enabled during fault clear");
  clear_ignore_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (!clr_f && !$past(!clr_f) == 1'b0 && run) |=> run)
    else $error("Sleep honoured during fault clear");
  sleep_reset_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    asleep |=> ocp_q == '0 && oe_q == '0)
    else $error("Logic not reset in sleep");
  sleep_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    asleep && sleep_req_f |=> asleep)
    else $error("Left sleep while request still low");
  wake_time_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    wake_entry |-> not_running_yet)
    else $error("Driving began too soon after wake");
  wake_count_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    $rose(run) |-> $past(wake_cnt_q) == WAKE_LAST)
    else $error("Run entered before the wake count ended");
  ocp_trip_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    $rose(ocp_q[0]) |-> $past(ocp_cnt_q[0]) == OCP_LAST)
    else $error("Overcurrent latched at wrong deglitch count");
  ocp_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    ocp_q[1] && !latch_clear |=> ocp_q[1] && !oe_q[1])
    else $error("Overcurrent shutdown released without clear");
  ocp_fault_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    $rose(ocp_q[2]) |=> error_indicator_n_oe)
    else $error("Overcurrent did not pull the fault output");
  temp_trip_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    $rose(otemp_q) |-> $past(temp_f) > half_bridge_pkg::TEMP_TRIP_C)
    else $error("Over-temperature tripped below threshold");
  temp_off_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    otemp_q |=> oe_q == '0 && error_indicator_n_oe)
    else $error("Outputs live during over-temperature");
  supply_low_lockout_off_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    supply_low_lockout_f |=> oe_q == '0 && ocp_q == '0 && error_indicator_n_oe)
    else $error("Undervoltage did not shut down and reset");
  fault_pin_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    error_indicator_n_oe == $past((|ocp_q) | otemp_q | supply_low_lockout_f))
    else $error("Fault output disagrees with fault state");
endmodule : triple_half_bridge_control
`default_nettype wire

// ==== design/half_bridge_pkg.sv ====
// Constants, types and register map of the triple half-bridge controller
`default_nettype none
package half_bridge_pkg;
  localparam int unsigned CLOCK_KHZ        = 125000;
  localparam int unsigned WAKE_TIME_MS     = 1;
  localparam int unsigned WAKE_CYCLES      = WAKE_TIME_MS * CLOCK_KHZ;
  localparam int unsigned OCP_DEGLITCH_US  = 5;
  localparam int unsigned OCP_CYCLES       = OCP_DEGLITCH_US * CLOCK_KHZ / 1000;
  localparam logic [7:0]  TEMP_TRIP_C      = 8'h96;
  localparam logic [7:0]  TEMP_RESUME_C    = 8'h82;
  localparam int unsigned CHANNELS         = 3;
  // Avalon word addresses (byte address bits 3:2)
  localparam logic [1:0]  STATUS_ADDR      = 2'h0;
  localparam logic [1:0]  MASK_ADDR        = 2'h1;
  localparam logic [1:0]  LIVE_ADDR        = 2'h2;
  // Event and live-state bit layout
  localparam int unsigned EV_OCP_LSB       = 0;
  localparam int unsigned EV_TEMP          = 3;
  localparam int unsigned EV_SUPPLY_LOW_LOCKOUT          = 4;
  localparam int unsigned EV_READY         = 5;
  localparam int unsigned EV_WIDTH         = 6;
  localparam logic [EV_WIDTH-1:0] MASK_RESET = 6'h00;
  localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;

  typedef struct packed {
    logic [CHANNELS-1:0] enable;
    logic [CHANNELS-1:0] level;
  } bridge_cmd_type;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_WAKE,
    ST_RUN
  } power_state_type;
endpackage : half_bridge_pkg
`default_nettype wire

// ==== verification/motor_controller_model.sv ====
// Behavioural model of the motor controller that drives the command, sleep and fault-clear pin inputs
`default_nettype none
module motor_controller_model #(
  parameter int unsigned WAKE_CYCLES = 20
) (
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire half_bridge_pkg::bridge_cmd_type want_cmd,
  input  wire logic                            want_sleep_n,
  input  wire logic                            want_clear_n,
  output half_bridge_pkg::bridge_cmd_type      bridge_cmd,
  output logic                                 low_power_request_n,
  output logic                                 fault_clear_n,
  output logic                                 settled
);
  timeunit 1ns;
  timeprecision 100ps;
  // Margin covers the input synchronisers on the far side
  localparam logic [15:0] SETTLE = 16'(WAKE_CYCLES + 10);
  logic [15:0] wait_q;
  assign settled = (wait_q == SETTLE);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bridge_cmd          <= '0;
      low_power_request_n <= 1'b1;
      fault_clear_n       <= 1'b1;
      wait_q              <= 16'h0000;
    end else begin
      bridge_cmd          <= want_cmd;
      low_power_request_n <= want_sleep_n;
      fault_clear_n       <= want_clear_n;
      if (!want_sleep_n) begin
        wait_q <= 16'h0000;
      end else if (wait_q != SETTLE) begin
        wait_q <= wait_q + 16'h0001;
      end
    end
  end
endmodule : motor_controller_model
`default_nettype wire

// ==== verification/triple_half_bridge_control_tb.sv ====
// Self-checking testbench of the triple half-bridge controller
`default_nettype none
module triple_half_bridge_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WAKE = 20;
  logic clock, rst_n, want_sleep_n, want_clear_n, settled;
  half_bridge_pkg::bridge_cmd_type want_cmd, bridge_cmd;
  logic low_power_request_n, fault_clear_n, motor_supply_low, irq;
  logic [2:0] high_side_limit, low_side_limit, phase_output, oe;
  logic [7:0] die_temp_c;
  logic charge_pump_run, error_n_out, error_oe, read, write, waitrequest;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rd;
  int failures, comparisons, seed;

  motor_controller_model #(.WAKE_CYCLES(WAKE)) u_ctrl (
    .clock(clock), .rst_n(rst_n), .want_cmd(want_cmd),
    .want_sleep_n(want_sleep_n), .want_clear_n(want_clear_n),
    .bridge_cmd(bridge_cmd), .low_power_request_n(low_power_request_n),
    .fault_clear_n(fault_clear_n), .settled(settled));

  triple_half_bridge_control #(.WAKE_CYCLES(WAKE), .OCP_CYCLES(8)) u_dut (
    .clock(clock), .rst_n(rst_n), .bridge_cmd(bridge_cmd),
    .low_power_request_n(low_power_request_n),
    .fault_clear_n(fault_clear_n), .high_side_limit(high_side_limit),
    .low_side_limit(low_side_limit), .motor_supply_low(motor_supply_low),
    .die_temp_c(die_temp_c), .phase_output(phase_output),
    .phase_output_oe(oe), .charge_pump_run(charge_pump_run),
    .error_indicator_n_out(error_n_out), .error_indicator_n_oe(error_oe),
    .irq(irq), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One Avalon access; waitrequest and readdata are sampled at the
  // rising edge that takes the request, then the request is dropped
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge clock);
    read      <= !wr;
    write     <= wr;
    address   <= a;
    writedata <= wd;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      failures++;
      summarize();
    end
    data = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask : settle

  task automatic wait_settled;
    int n;
    n = 0;
    while (settled !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check("controller settled", 32'h1, {31'h0, settled});
  endtask : wait_settled

  task automatic check_out(input logic [2:0] en, input logic [2:0] lv,
                           input logic fault);
    check("drive enables", {29'h0, en}, {29'h0, oe});
    check("drive levels", {29'h0, en & lv}, {29'h0, phase_output & en});
    check("fault pull", {31'h0, fault}, {31'h0, error_oe});
  endtask : check_out

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize();
  end

  initial begin
    seed = 32'h732f4823;
    rst_n = 1'b0;
    want_cmd = '0;
    want_sleep_n = 1'b1;
    want_clear_n = 1'b1;
    high_side_limit = 3'h0;
    low_side_limit = 3'h0;
    motor_supply_low = 1'b0;
    die_temp_c = 8'h19;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    settle(4);
    rst_n <= 1'b1;
    wait_settled();
    bus(1'b0, 4'h8, 32'h0, rd);
    check("live after power-up", 32'h20, rd);
    bus(1'b0, 4'h0, 32'h0, rd);
    check("status power-up", 32'h20, rd);
    bus(1'b0, 4'h0, 32'h0, rd);
    check("status cleared", 32'h0, rd);
    bus(1'b0, 4'hc, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    for (int i = 0; i < 12; i++) begin
      want_cmd <= 6'($random(seed));
      die_temp_c <= 8'($random(seed) & 32'h7f);
      settle(10);
      check_out(want_cmd.enable, want_cmd.level, 1'b0);
    end
    want_cmd <= '{enable: 3'h7, level: 3'h5};
    die_temp_c <= 8'h96;
    settle(10);
    check_out(3'h7, 3'h5, 1'b0);
    die_temp_c <= 8'h97;
    settle(10);
    check_out(3'h0, 3'h0, 1'b1);
    check("masked irq", 32'h0, {31'h0, irq});
    die_temp_c <= 8'h40;
    settle(10);
    check_out(3'h7, 3'h5, 1'b0);
    bus(1'b0, 4'h0, 32'h0, rd);
    check("status temp", 32'h08, rd);
    bus(1'b1, 4'h4, 32'h03, rd);
    high_side_limit <= 3'h1;
    low_side_limit <= 3'h2;
    settle(18);
    high_side_limit <= 3'h0;
    low_side_limit <= 3'h0;
    settle(10);
    check_out(3'h4, 3'h5, 1'b1);
    check("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, 4'h0, 32'h0, rd);
    check("status overcurrent", 32'h03, rd);
    settle(2);
    check("irq cleared", 32'h0, {31'h0, irq});
    settle(20);
    check_out(3'h4, 3'h5, 1'b1);
    want_clear_n <= 1'b0;
    want_sleep_n <= 1'b0;
    settle(10);
    check_out(3'h0, 3'h0, 1'b0);
    check("pump during clear", 32'h1, {31'h0, charge_pump_run});
    want_sleep_n <= 1'b1;
    settle(4);
    want_clear_n <= 1'b1;
    settle(10);
    check_out(3'h7, 3'h5, 1'b0);
    motor_supply_low <= 1'b1;
    settle(10);
    check_out(3'h0, 3'h0, 1'b1);
    motor_supply_low <= 1'b0;
    settle(10);
    check_out(3'h7, 3'h5, 1'b0);
    high_side_limit <= 3'h4;
    settle(18);
    high_side_limit <= 3'h0;
    want_sleep_n <= 1'b0;
    settle(10);
    check("pump asleep", 32'h0, {31'h0, charge_pump_run});
    check_out(3'h0, 3'h0, 1'b0);
    want_cmd <= '{enable: 3'h3, level: 3'h2};
    want_clear_n <= 1'b0;
    settle(10);
    check_out(3'h0, 3'h0, 1'b0);
    want_clear_n <= 1'b1;
    want_sleep_n <= 1'b1;
    settle(6);
    check_out(3'h0, 3'h0, 1'b0);
    bus(1'b0, 4'h8, 32'h0, rd);
    check("live during wake", 32'h0, rd);
    wait_settled();
    check_out(3'h3, 3'h2, 1'b0);
    check("open drain level", 32'h0, {31'h0, error_n_out});
    summarize();
  end
endmodule : triple_half_bridge_control_tb
`default_nettype wire
